/* File: verilog/cpusw_pkg.sv */
// package: layout, reset values and carriers of the alu status word
package cpusw_pkg;
    // bit positions of the status word
    localparam int unsigned HALF_CARRY_POS = 8;
    localparam int unsigned PRIO_HI_POS    = 7;
    localparam int unsigned PRIO_LO_POS    = 5;
    localparam int unsigned REPEAT_POS     = 4;
    localparam int unsigned NEG_POS        = 3;
    localparam int unsigned EXCESS_POS     = 2;
    localparam int unsigned ZERO_POS       = 1;
    localparam int unsigned CARRY_POS      = 0;
    // reset value of every stored bit
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    // mask of bits software may write
    localparam logic [15:0] WRITE_MASK     = 16'h01EF;
    // priority code that blocks user interrupts
    localparam logic [2:0]  PRIO_BLOCK_ALL = 3'h7;
    // reset values of the registered level and block outputs
    localparam logic [3:0]  EFF_PRIO_RESET = 4'h0;
    localparam logic        BLOCKED_RESET  = 1'b0;

    // flag update from the alu for one operation
    typedef struct packed {
        logic       update;      // an operation affects flags this cycle
        logic       byte_op;     // byte sized operation
        logic [7:0] nib_cy;      // carries out of each low bit of result
        logic       neg_en;      // operation affects negative flag
        logic       neg;         // result negative
        logic       excess_en;   // operation affects overflow flag
        logic       excess;      // signed overflow occurred
        logic       zero_en;     // operation affects zero flag
        logic       zero;        // result is zero
        logic       carry_en;    // operation affects carry flag
        logic       carry;       // carry out of msb
        logic       hc_en;       // operation affects half carry flag
    } cpusw_flags_t;

    // software write of the status word
    typedef struct packed {
        logic        wr_en;      // write strobe
        logic [15:0] wr_data;    // value written
    } cpusw_write_t;
endpackage

/* File: verilog/cpusw_status_word.sv */
// module: the cpu alu status word register with flag update logic
//
// How it works
// - half carry from bit 3 or 7
// - priority level bits 7-5, writable, reset zero
// - level seven blocks all user interrupts
// - repeat indicator read-only, sequencer driven, reset zero
// - repeat indicator high while loop runs
// - extension bit lifts level to 8..15
// - zero result sets zero flag, nonzero clears
// - negative flag follows result sign
`timescale 1ns/1ps
module cpusw_status_word
    import cpusw_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire cpusw_pkg::cpusw_flags_t alu_flags,
    input  wire cpusw_pkg::cpusw_write_t sw_write,
    input  wire logic                    repeat_busy,
    input  wire logic                    priority_level_extension,
    output logic [15:0]                  alu_status_word,
    output logic [3:0]                   effective_priority,
    output logic                         user_irq_blocked
);
    import cpusw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    logic        half_carry_flag_reg;                // bit 8
    logic        half_carry_flag_next;
    logic [2:0]  cpu_priority_level_reg;             // bits 7-5
    logic [2:0]  cpu_priority_level_next;
    logic        repeat_loop_active_reg;             // bit 4
    logic        repeat_loop_active_next;
    logic        neg_flag_reg;                       // bit 3
    logic        neg_flag_next;
    logic        twos_complement_excess_flag_reg;    // bit 2
    logic        twos_complement_excess_flag_next;
    logic        zero_flag_reg;                      // bit 1
    logic        zero_flag_next;
    logic        carry_flag_reg;                     // bit 0
    logic        carry_flag_next;
    logic [15:0] status_out_reg;                     // registered view
    logic [15:0] status_out_next;
    logic [3:0]  eff_prio_reg;                       // registered level
    logic [3:0]  eff_prio_next;
    logic        blocked_reg;                        // registered block
    logic        blocked_next;
    logic [15:0] sw_bits;                            // masked write value
    logic        sw_take;                            // write strobe seen
    logic        hc_sel;                             // chosen half carry

    ////////////////////////////////////////////////////////////////////
    // notes for users of this word
    // - every change shows on the ports one edge after it is taken
    // - a write and an alu update may share a cycle; the write lands in
    //   the flags that the update leaves alone
    // - the repeat bit cannot be written: a stray write during a loop
    //   would otherwise end the loop as seen by software
    // - the blocked output is high for level seven and for every
    //   extended level, since those sit above all user levels
    // - the extension bit is owned elsewhere; this word only reads it

    ////////////////////////////////////////////////////////////////////
    // write decode: only the stored bits of a software write count;
    // the mask keeps bits 15 to 9 and the repeat bit out of every load
    always_comb begin
        // strobe passed on as is, one cycle wide
        sw_take = sw_write.wr_en;
        // unstored bits forced low before anything reads the value
        sw_bits = sw_write.wr_data & WRITE_MASK;
    end

    ////////////////////////////////////////////////////////////////////
    // half carry select: the carry column depends on operand size
    always_comb begin
        // byte results carry out of bit 3, word results out of bit 7
        if (alu_flags.byte_op) begin
            hc_sel = alu_flags.nib_cy[3];
        end else begin
            hc_sel = alu_flags.nib_cy[7];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag group next state: software write first, alu update after;
    // a write and an update in one cycle give a single outcome, the alu
    // winning flag by flag and the write keeping the flags it alone set
    always_comb begin
        // hold every flag unless something below changes it
        half_carry_flag_next             = half_carry_flag_reg;
        neg_flag_next                    = neg_flag_reg;
        twos_complement_excess_flag_next = twos_complement_excess_flag_reg;
        zero_flag_next                   = zero_flag_reg;
        carry_flag_next                  = carry_flag_reg;
        // software write loads the five flags from the masked value
        if (sw_take) begin
            half_carry_flag_next             = sw_bits[HALF_CARRY_POS];
            neg_flag_next                    = sw_bits[NEG_POS];
            twos_complement_excess_flag_next = sw_bits[EXCESS_POS];
            zero_flag_next                   = sw_bits[ZERO_POS];
            carry_flag_next                  = sw_bits[CARRY_POS];
        end
        // alu update applied last so each enabled flag wins
        if (alu_flags.update) begin
            // half carry from the selected low-order carry
            if (alu_flags.hc_en) begin
                half_carry_flag_next = hc_sel;
            end
            // sign of result, zero counts as non-negative
            if (alu_flags.neg_en) begin
                neg_flag_next = alu_flags.neg;
            end
            // signed overflow of the operation
            if (alu_flags.excess_en) begin
                twos_complement_excess_flag_next = alu_flags.excess;
            end
            // zero result sets the flag, a nonzero result clears it
            if (alu_flags.zero_en) begin
                zero_flag_next = alu_flags.zero;
            end
            // carry or borrow out of the msb
            if (alu_flags.carry_en) begin
                carry_flag_next = alu_flags.carry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control group next state: priority level and repeat indicator
    always_comb begin
        // priority level holds unless software writes it
        cpu_priority_level_next = cpu_priority_level_reg;
        // a write loads all three level bits at once
        if (sw_take) begin
            cpu_priority_level_next =
                sw_bits[PRIO_HI_POS:PRIO_LO_POS];
        end
        // sequencer alone drives the repeat indicator, writes skip it
        repeat_loop_active_next = repeat_busy;
    end

    ////////////////////////////////////////////////////////////////////
    // view next state: built from next values so the outputs are
    // flip-flops yet still show a change one edge after it is taken
    always_comb begin
        // unstored bits stay low
        status_out_next = STATUS_RESET;
        // stored bits placed at their positions
        status_out_next[HALF_CARRY_POS] = half_carry_flag_next;
        status_out_next[PRIO_HI_POS:PRIO_LO_POS] = cpu_priority_level_next;
        status_out_next[REPEAT_POS]     = repeat_loop_active_next;
        status_out_next[NEG_POS]        = neg_flag_next;
        status_out_next[EXCESS_POS]     = twos_complement_excess_flag_next;
        status_out_next[ZERO_POS]       = zero_flag_next;
        status_out_next[CARRY_POS]      = carry_flag_next;
        // extension bit adds eight to the level
        eff_prio_next = {priority_level_extension,
                         cpu_priority_level_next};
        // level seven, or any level above it, blocks user interrupts
        blocked_next  = priority_level_extension ||
            (cpu_priority_level_next == PRIO_BLOCK_ALL);
    end

    ////////////////////////////////////////////////////////////////////
    // flag group registers, synchronous reset to the power-on value
    always_ff @(posedge core_clk) begin
        // reset clears every flag
        if (sys_rst) begin
            half_carry_flag_reg             <= STATUS_RESET[HALF_CARRY_POS];
            neg_flag_reg                    <= STATUS_RESET[NEG_POS];
            twos_complement_excess_flag_reg <= STATUS_RESET[EXCESS_POS];
            zero_flag_reg                   <= STATUS_RESET[ZERO_POS];
            carry_flag_reg                  <= STATUS_RESET[CARRY_POS];
        end else begin
            // each flag takes its next value
            half_carry_flag_reg             <= half_carry_flag_next;
            neg_flag_reg                    <= neg_flag_next;
            twos_complement_excess_flag_reg <=
                twos_complement_excess_flag_next;
            zero_flag_reg                   <= zero_flag_next;
            carry_flag_reg                  <= carry_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control group registers, synchronous reset
    always_ff @(posedge core_clk) begin
        // reset drops the level to zero and the repeat bit low
        if (sys_rst) begin
            cpu_priority_level_reg <=
                STATUS_RESET[PRIO_HI_POS:PRIO_LO_POS];
            repeat_loop_active_reg <= STATUS_RESET[REPEAT_POS];
        end else begin
            // level and repeat bit take their next values
            cpu_priority_level_reg <= cpu_priority_level_next;
            repeat_loop_active_reg <= repeat_loop_active_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // view registers: the only things the ports see
    always_ff @(posedge core_clk) begin
        // reset shows the power-on word and an open level
        if (sys_rst) begin
            status_out_reg <= STATUS_RESET;
            eff_prio_reg   <= EFF_PRIO_RESET;
            blocked_reg    <= BLOCKED_RESET;
        end else begin
            // view follows the next state of both groups
            status_out_reg <= status_out_next;
            eff_prio_reg   <= eff_prio_next;
            blocked_reg    <= blocked_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops, so no port carries a
    // combinational path from any input
    assign alu_status_word    = status_out_reg;
    assign effective_priority = eff_prio_reg;
    assign user_irq_blocked   = blocked_reg;
endmodule

/* File: sim/cpusw_checker.sv */
// checker: port assertions for the alu status word
`timescale 1ns/1ps
module cpusw_checker
    import cpusw_pkg::*;
(
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire cpusw_pkg::cpusw_flags_t alu_flags,
    input wire cpusw_pkg::cpusw_write_t sw_write,
    input wire logic                    repeat_busy,
    input wire logic                    priority_level_extension,
    input wire logic [15:0]             alu_status_word,
    input wire logic [3:0]              effective_priority,
    input wire logic                    user_irq_blocked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // the unimplemented bits never show a one
    upper_zero_a: assert property (
        alu_status_word[15:9] == 7'h00) else $error("upper bits set");
    // repeat bit follows the sequencer one cycle on
    repeat_follow_a: assert property (
        !$past(sys_rst) |-> alu_status_word[4] == $past(repeat_busy))
        else $error("repeat bit wrong");
    // level seven or the extension blocks user requests
    block_level_a: assert property (
        user_irq_blocked == (&alu_status_word[7:5] | effective_priority[3]))
        else $error("blocking wrong");
    // effective level joins extension and status level
    eff_prio_a: assert property (
        !$past(sys_rst) |-> effective_priority ==
        {$past(priority_level_extension), alu_status_word[7:5]})
        else $error("effective level wrong");
    // half carry from bit 3 for bytes, bit 7 for words
    half_carry_a: assert property (
        !$past(sys_rst) && $past(alu_flags.update && alu_flags.hc_en)
        |-> alu_status_word[8] == $past(alu_flags.byte_op ?
        alu_flags.nib_cy[3] : alu_flags.nib_cy[7]))
        else $error("half carry wrong");
    // a nonzero result clears the zero flag
    zero_clear_a: assert property (
        !$past(sys_rst) && $past(alu_flags.update && alu_flags.zero_en
        && !alu_flags.zero) |-> !alu_status_word[1])
        else $error("zero flag not cleared");
    // a lone write lands in every writable bit
    sw_write_a: assert property (
        !$past(sys_rst) && $past(sw_write.wr_en && !alu_flags.update)
        |-> {alu_status_word[8:5], alu_status_word[3:0]} ==
        $past({sw_write.wr_data[8:5], sw_write.wr_data[3:0]}))
        else $error("write not applied");
    // the alu carry wins over a same-cycle write
    alu_wins_a: assert property (
        !$past(sys_rst) && $past(sw_write.wr_en && alu_flags.update &&
        alu_flags.carry_en) |-> alu_status_word[0] == $past(alu_flags.carry))
        else $error("write beat the alu");
    // a zero result sets the zero flag
    zero_set_a: assert property (
        !$past(sys_rst) && $past(alu_flags.update && alu_flags.zero_en
        && alu_flags.zero) |-> alu_status_word[1])
        else $error("zero flag not set");
    // the negative flag takes the sign of an affecting result
    neg_follow_a: assert property (
        !$past(sys_rst) && $past(alu_flags.update && alu_flags.neg_en)
        |-> alu_status_word[3] == $past(alu_flags.neg))
        else $error("negative flag wrong");
endmodule
bind cpusw_status_word cpusw_checker u_cpusw_checker (.core_clk, .sys_rst,
    .alu_flags, .sw_write, .repeat_busy, .priority_level_extension,
    .alu_status_word, .effective_priority, .user_irq_blocked);

/* File: sim/cpu_alu_status_word_tb.sv */
// testbench: writes and flag updates on the alu status word
`timescale 1ns/1ps
module cpu_alu_status_word_tb;
    import cpusw_pkg::*;
    logic         core_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         repeat_busy = 1'b0;
    logic         priority_level_extension = 1'b0;
    cpusw_flags_t alu_flags = '0;
    cpusw_write_t sw_write = '0;
    logic [15:0]  alu_status_word;
    logic [3:0]   effective_priority;
    logic         user_irq_blocked;
    int           miscompares = 0;
    int           n_tests = 0;
    always #5 core_clk = ~core_clk;
    cpusw_status_word u_cpusw_status_word (.core_clk, .sys_rst, .alu_flags,
        .sw_write, .repeat_busy, .priority_level_extension, .alu_status_word,
        .effective_priority, .user_irq_blocked);
    // compare one 16-bit result
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one cycle of write and flag update from a falling edge, then compare
    task op(input logic we, input logic [15:0] d, input logic [18:0] f,
            input logic [15:0] exp);
        sw_write = '{we, d};
        alu_flags = cpusw_flags_t'(f);
        @(negedge core_clk);
        chk(alu_status_word, exp);
    endtask
    task close_out;
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(alu_status_word, 16'h0000);
        op(1'b1, 16'hFFFF, 19'h00000, 16'h01EF);
        sys_rst = 1'b1;
        op(1'b0, 16'h0000, 19'h00000, 16'h0000);
        sys_rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            priority_level_extension = i[3];
            op(1'b1, {8'h00, i[2:0], 5'h00}, 19'h00000,
               {8'h00, i[2:0], 5'h00});
            chk({11'h000, effective_priority, user_irq_blocked},
                {11'h000, i[3:0], i[3] | (&i[2:0])});
        end
        priority_level_extension = 1'b0;
        repeat_busy = 1'b1;
        op(1'b1, 16'h0000, 19'h00000, 16'h0010);
        repeat_busy = 1'b0;
        op(1'b0, 16'h0000, 19'h00000, 16'h0000);
        op(1'b0, 16'h0000, 19'h61001, 16'h0100);
        op(1'b0, 16'h0000, 19'h41001, 16'h0000);
        op(1'b0, 16'h0000, 19'h50001, 16'h0100);
        op(1'b0, 16'h0000, 19'h70001, 16'h0000);
        op(1'b1, 16'h0002, 19'h00000, 16'h0002);
        op(1'b0, 16'h0000, 19'h40018, 16'h0002);
        op(1'b0, 16'h0000, 19'h40010, 16'h0000);
        op(1'b0, 16'h0000, 19'h40018, 16'h0002);
        op(1'b0, 16'h0000, 19'h40070, 16'h0004);
        op(1'b0, 16'h0000, 19'h401C0, 16'h0008);
        op(1'b0, 16'h0000, 19'h40106, 16'h0001);
        op(1'b1, 16'h00E1, 19'h40184, 16'h00E8);
        close_out();
    end
endmodule
